// ---- core/spfs_regs.vh ----
// spfs_regs.vh: constants for the self-program flash section control block
// assumes 8k-byte flash, 4k words addressed by 12-bit word address, 32-word pages
`ifndef SPFS_REGS_VH
`define SPFS_REGS_VH

`define SPFS_AW 12
`define SPFS_DW 16
`define SPFS_PAGE_LSB 5
`define SPFS_PW 7
// halting region starts at this word address, independent of fuses
`define SPFS_HALT_BASE 12'hc00
// boot loader start per boot size fuse code 0..3 (all inside the halting region)
`define SPFS_BOOT_BASE0 12'hc00
`define SPFS_BOOT_BASE1 12'he00
`define SPFS_BOOT_BASE2 12'hf00
`define SPFS_BOOT_BASE3 12'hf80
// value returned for blocked concurrent-region reads
`define SPFS_BLOCKED_DATA 16'hffff
// operation codes
`define SPFS_OP_LOAD 2'h0
`define SPFS_OP_ERASE 2'h1
`define SPFS_OP_WRITE 2'h2
`define SPFS_OP_LOCK 2'h3
// default array busy time in cycles (4 ms at 40 MHz)
`define SPFS_OP_TIME_US 4000
`define SPFS_CLK_MHZ 40
`define SPFS_OP_CYCLES 18'h27100
`define SPFS_CW 18
`define SPFS_ONE_CW 18'h00001
`define SPFS_ZERO_CW 18'h00000

`endif

// ---- core/spfs_region_dec.v ----
// spfs_region_dec.v: classifies a word address into flash regions
// assumes fuse inputs stable; purely combinational
`include "spfs_regs.vh"
`timescale 1ns/1ps

module spfs_region_dec (
	input wire [`SPFS_AW-1:0] addr_i,
	input wire [1:0] boot_size_fuses_i,
	output reg in_boot_o,
	output reg in_halt_o
);

reg [`SPFS_AW-1:0] boot_base;

// boot base from fuses; halting boundary is fixed
always @* begin
	if (boot_size_fuses_i == 2'h0) begin
		boot_base = `SPFS_BOOT_BASE0;
	end else if (boot_size_fuses_i == 2'h1) begin
		boot_base = `SPFS_BOOT_BASE1;
	end else if (boot_size_fuses_i == 2'h2) begin
		boot_base = `SPFS_BOOT_BASE2;
	end else begin
		boot_base = `SPFS_BOOT_BASE3;
	end
	in_boot_o = (addr_i >= boot_base);
	in_halt_o = (addr_i >= `SPFS_HALT_BASE);
end

endmodule

// ---- core/spfs_lock_chk.v ----
// spfs_lock_chk.v: decides whether a lock-bit pair permits a write and a read
// assumes lock bits active low (0 = programmed)
`include "spfs_regs.vh"
`timescale 1ns/1ps

module spfs_lock_chk (
	input wire [1:0] lock_bits_i,
	output wire write_ok_o,
	output wire cross_read_ok_o
);

// bit 0 clear blocks writes; bit 1 clear blocks cross-region reads
assign write_ok_o = lock_bits_i[0];
assign cross_read_ok_o = lock_bits_i[1];

endmodule

// ---- core/spfs_ctrl.v ----
// spfs_ctrl.v: self-programming sequencer with region decode and fetch gating
// assumes core holds requests until acked; array ops finish when the OP_CYCLES count runs out
//
// Notes on behaviour
// - flash split into application and boot loader regions by boot size fuses.
// - store-program requests issued from application region are ignored.
// - store-program from boot loader may target any flash address.
// - lock set 0 guards application region, lock set 1 guards boot region.
// - fixed concurrent/halting boundary independent of boot size fuses.
// - concurrent or halting behaviour chosen from the pointer page address.
// - concurrent-region operation keeps core running, halting reads served.
// - halting-region operation stalls core for whole operation, no reads.
// - no valid code returned from concurrent region while it is blocked.
// - busy flag reads one while a concurrent-region op keeps that region blocked.
// - boot loader region always lies inside the halting region.
// - busy flag set when erase or write to concurrent region starts.
// - busy flag cleared by read re-enable after completion or by page load.
`include "spfs_regs.vh"
`timescale 1ns/1ps

module spfs_ctrl #(
	parameter [`SPFS_CW-1:0] OP_CYCLES = `SPFS_OP_CYCLES
) (
	input wire mclk_i,
	input wire rst_i,
	input wire [1:0] boot_size_fuses_i,
	input wire [1:0] lock_set0_i,
	input wire [1:0] lock_set1_i,
	input wire rd_req_i,
	input wire [`SPFS_AW-1:0] rd_addr_i,
	input wire [`SPFS_AW-1:0] pc_i,
	input wire spm_req_i,
	input wire [1:0] spm_op_i,
	input wire [`SPFS_AW-1:0] spm_ptr_i,
	input wire [`SPFS_DW-1:0] spm_data_i,
	input wire concurrent_region_read_reenable_i,
	input wire [`SPFS_DW-1:0] arr_rdata_i,
	output reg rd_valid_o,
	output reg [`SPFS_DW-1:0] rd_data_o,
	output reg spm_ack_o,
	output reg spm_rejected_o,
	output reg core_stall_o,
	output reg concurrent_region_busy_flag_o,
	output reg spm_busy_o,
	output reg arr_rd_o,
	output reg [`SPFS_AW-1:0] arr_addr_o,
	output reg arr_erase_o,
	output reg arr_write_o,
	output reg arr_load_o,
	output reg [`SPFS_DW-1:0] arr_wdata_o
);

// sequencer states; DONE lasts one cycle and marks completion
localparam ST_IDLE = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_DONE = 2'h2;

// sequencer state
reg [1:0] state_reg;
reg [1:0] state_next;
reg [`SPFS_CW-1:0] cnt_reg;
reg [`SPFS_CW-1:0] cnt_next;
reg halt_op_reg;
reg halt_op_next;
reg busy_flag_next;
reg op_done_reg;
reg op_done_next;
// read return pipeline
reg rd_pend_reg;
reg rd_pend_blk_reg;
// region and lock decode
wire pc_in_boot;
wire tgt_in_boot;
wire tgt_in_halt;
wire rd_in_boot;
wire rd_in_halt;
wire app_wr_ok;
wire app_rd_ok;
wire boot_wr_ok;
wire boot_rd_ok;
wire tgt_wr_ok;
wire rd_lock_ok;
wire spm_accept;
wire is_prog;
wire rd_blocked;
// output qualifiers
wire stall_next;
wire rd_refused;

////////////////////////////////////////////////////////////////////////////////
// region decode for the fetching pc, the pointer and the read address

spfs_region_dec u_pc_dec (
	.addr_i(pc_i),
	.boot_size_fuses_i(boot_size_fuses_i),
	.in_boot_o(pc_in_boot),
	.in_halt_o()
);

spfs_region_dec u_tgt_dec (
	.addr_i(spm_ptr_i),
	.boot_size_fuses_i(boot_size_fuses_i),
	.in_boot_o(tgt_in_boot),
	.in_halt_o(tgt_in_halt)
);

spfs_region_dec u_rd_dec (
	.addr_i(rd_addr_i),
	.boot_size_fuses_i(boot_size_fuses_i),
	.in_boot_o(rd_in_boot),
	.in_halt_o(rd_in_halt)
);

spfs_lock_chk u_lock_app (
	.lock_bits_i(lock_set0_i),
	.write_ok_o(app_wr_ok),
	.cross_read_ok_o(app_rd_ok)
);

spfs_lock_chk u_lock_boot (
	.lock_bits_i(lock_set1_i),
	.write_ok_o(boot_wr_ok),
	.cross_read_ok_o(boot_rd_ok)
);

////////////////////////////////////////////////////////////////////////////////
// request qualification

// lock set chosen by target region; any address reachable from boot
assign tgt_wr_ok = tgt_in_boot ? boot_wr_ok : app_wr_ok;

// cross-region reads only: same-region code always reads itself
assign rd_lock_ok = (rd_in_boot == pc_in_boot) ? 1'b1 :
	(rd_in_boot ? boot_rd_ok : app_rd_ok);

// only erase and write busy the array; load and lock just ack
assign is_prog = (spm_op_i == `SPFS_OP_ERASE) || (spm_op_i == `SPFS_OP_WRITE);

// store-program accepted only from boot region code
assign spm_accept = spm_req_i && pc_in_boot && (state_reg == ST_IDLE) &&
	(!is_prog || tgt_wr_ok);

// boot region sits above the halting boundary for every fuse code, so
// a boot-region fetch is never blocked; the decoders keep that true
assign rd_blocked = !rd_in_halt && (concurrent_region_busy_flag_o || state_reg != ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// sequencer next state

always @* begin
	state_next = state_reg;
	cnt_next = cnt_reg;
	halt_op_next = halt_op_reg;
	busy_flag_next = concurrent_region_busy_flag_o;
	op_done_next = op_done_reg;
	case (state_reg)
		ST_IDLE: begin
			// a starting op wins over a clear in the same cycle
			if (spm_accept && is_prog) begin
				state_next = ST_RUN;
				cnt_next = OP_CYCLES;
				// the pointer's page picks concurrent or halting behaviour
				halt_op_next = tgt_in_halt;
				op_done_next = 1'b0;
				// only concurrent-region targets raise the busy flag
				if (!tgt_in_halt) begin
					busy_flag_next = 1'b1;
				end
			end else if (spm_accept && spm_op_i == `SPFS_OP_LOAD) begin
				// page load clears the flag at any idle time
				busy_flag_next = 1'b0;
			end else if (concurrent_region_read_reenable_i && op_done_reg) begin
				// re-enable counts only once an op has finished
				busy_flag_next = 1'b0;
			end
		end
		ST_RUN: begin
			// count the array busy time down to one
			if (cnt_reg == `SPFS_ONE_CW) begin
				state_next = ST_DONE;
			end
			cnt_next = cnt_reg - `SPFS_ONE_CW;
		end
		ST_DONE: begin
			// completion arms the read re-enable
			state_next = ST_IDLE;
			cnt_next = `SPFS_ZERO_CW;
			halt_op_next = 1'b0;
			op_done_next = 1'b1;
		end
		default: begin
			// unused code falls back to idle
			state_next = ST_IDLE;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// state registers

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		state_reg <= ST_IDLE;
		cnt_reg <= `SPFS_ZERO_CW;
		halt_op_reg <= 1'b0;
		op_done_reg <= 1'b0;
		concurrent_region_busy_flag_o <= 1'b0;
	end else begin
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		halt_op_reg <= halt_op_next;
		op_done_reg <= op_done_next;
		// the flag flop is the output itself, no extra delay
		concurrent_region_busy_flag_o <= busy_flag_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// stall and read qualifiers shared by the output processes

// stall follows the next state, so it rises on the accepting edge
assign stall_next = halt_op_next && (state_next != ST_IDLE);
// a read meeting a store-program accept loses the array address
assign rd_refused = rd_blocked || !rd_lock_ok || spm_accept;

////////////////////////////////////////////////////////////////////////////////
// core side handshake outputs

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		spm_ack_o <= 1'b0;
		spm_rejected_o <= 1'b0;
		core_stall_o <= 1'b0;
		spm_busy_o <= 1'b0;
	end else begin
		// ack and refusal answer the taking edge
		spm_ack_o <= spm_accept;
		// refused request raises spm_rejected_o for one cycle, ack never comes
		spm_rejected_o <= spm_req_i && (state_reg == ST_IDLE) && !spm_accept;
		spm_busy_o <= (state_next != ST_IDLE);
		// stall for whole halting operation
		core_stall_o <= stall_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// array commands; the array answers for the address already on its port

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		// array idle, address parked at zero
		arr_rd_o <= 1'b0;
		arr_addr_o <= {`SPFS_AW{1'b0}};
		arr_erase_o <= 1'b0;
		arr_write_o <= 1'b0;
		arr_load_o <= 1'b0;
		arr_wdata_o <= {`SPFS_DW{1'b0}};
	end else begin
		// one-cycle command pulses
		arr_erase_o <= spm_accept && (spm_op_i == `SPFS_OP_ERASE);
		arr_write_o <= spm_accept && (spm_op_i == `SPFS_OP_WRITE);
		arr_load_o <= spm_accept && (spm_op_i == `SPFS_OP_LOAD);
		// write data follows the core every cycle
		arr_wdata_o <= spm_data_i;
		if (spm_accept) begin
			arr_addr_o <= spm_ptr_i;
			arr_rd_o <= 1'b0;
		end else begin
			arr_addr_o <= rd_addr_i;
			// halting reads go on except during halting ops
			arr_rd_o <= rd_req_i && !rd_blocked && !halt_op_reg && rd_lock_ok;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read return: the address leaves on the taking edge and the data comes back
// on the next one, so a read costs two edges; refusal is judged when taken

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		// no read pending, data shows the blocked value
		rd_pend_reg <= 1'b0;
		rd_pend_blk_reg <= 1'b0;
		rd_valid_o <= 1'b0;
		rd_data_o <= `SPFS_BLOCKED_DATA;
	end else begin
		rd_pend_reg <= rd_req_i && !stall_next;
		rd_pend_blk_reg <= rd_refused;
		// no answer at all while the core is held
		rd_valid_o <= rd_pend_reg && !stall_next;
		if (rd_pend_reg) begin
			if (rd_pend_blk_reg) begin
				rd_data_o <= `SPFS_BLOCKED_DATA;
			end else begin
				rd_data_o <= arr_rdata_i;
			end
		end
	end
end

endmodule

// ---- dv/spfs_arr_model.sv ----
// spfs_arr_model.sv: flash array seen by the sequencer
// assumes combinational read of the word at addr_i
`timescale 1ns/1ps
// content is a function of the address, so stale data is easy to spot
module spfs_arr_model (
	input wire [11:0] addr_i,
	output wire [15:0] rdata_o
);
	assign rdata_o = {4'ha, addr_i};
endmodule

// ---- dv/spfs_ctrl_checker.sv ----
// spfs_ctrl_checker.sv: port checks on the self-program sequencer
// assumes a short OP_CYCLES of at least 8 and boot base c00..f80
`timescale 1ns/1ps
module spfs_ctrl_checker (
	input wire mclk_i,
	input wire rst_i,
	input wire [1:0] boot_size_fuses_i,
	input wire [1:0] lock_set0_i,
	input wire rd_req_i,
	input wire [11:0] rd_addr_i,
	input wire [11:0] pc_i,
	input wire spm_req_i,
	input wire [1:0] spm_op_i,
	input wire [11:0] spm_ptr_i,
	input wire concurrent_region_read_reenable_i,
	input wire rd_valid_o,
	input wire [15:0] rd_data_o,
	input wire spm_ack_o,
	input wire spm_rejected_o,
	input wire core_stall_o,
	input wire concurrent_region_busy_flag_o,
	input wire spm_busy_o,
	input wire arr_erase_o,
	input wire arr_write_o,
	input wire arr_load_o
);
	wire [11:0] bb;
	wire go;
	wire pgm;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// boot base from fuses; request seen while idle
	assign bb = (boot_size_fuses_i == 2'h0) ? 12'hc00 : (boot_size_fuses_i == 2'h1) ? 12'he00 :
		(boot_size_fuses_i == 2'h2) ? 12'hf00 : 12'hf80;
	assign go = spm_req_i && !spm_busy_o;
	assign pgm = spm_ack_o && (arr_erase_o || arr_write_o);
	////////////////////////////////////////////////////////////////
	property p_rej; go && pc_i < bb |=> spm_rejected_o && !spm_ack_o; endproperty
	a_rej: assert property (p_rej) else $error("app store not refused");
	property p_acc; go && pc_i >= bb && spm_op_i == 2'h1 && spm_ptr_i < bb && lock_set0_i[0]
		|=> spm_ack_o && arr_erase_o; endproperty
	a_acc: assert property (p_acc) else $error("boot erase not taken");
	property p_lock; go && pc_i >= bb && spm_op_i == 2'h1 && spm_ptr_i < bb && !lock_set0_i[0]
		|=> !spm_ack_o; endproperty
	a_lock: assert property (p_lock) else $error("locked erase taken");
	property p_set; pgm && $past(spm_ptr_i) < 12'hc00 |-> concurrent_region_busy_flag_o; endproperty
	a_set: assert property (p_set) else $error("busy flag not set");
	property p_stall; pgm && $past(spm_ptr_i) >= 12'hc00 |-> core_stall_o [*8]; endproperty
	a_stall: assert property (p_stall) else $error("core not stalled");
	property p_run; pgm && $past(spm_ptr_i) < 12'hc00 |-> !core_stall_o [*8]; endproperty
	a_run: assert property (p_run) else $error("core stalled");
	property p_blk; rd_req_i && rd_addr_i < 12'hc00 && concurrent_region_busy_flag_o
		|-> ##2 rd_data_o == 16'hffff; endproperty
	a_blk: assert property (p_blk) else $error("blocked read leaked");
	property p_halt; core_stall_o |-> !rd_valid_o; endproperty
	a_halt: assert property (p_halt) else $error("read served in stall");
	property p_reen; concurrent_region_read_reenable_i && !spm_busy_o && !spm_req_i
		|=> !concurrent_region_busy_flag_o; endproperty
	a_reen: assert property (p_reen) else $error("reenable ignored");
	property p_load; spm_ack_o && arr_load_o |-> !concurrent_region_busy_flag_o; endproperty
	a_load: assert property (p_load) else $error("load kept busy flag");
endmodule
bind spfs_ctrl spfs_ctrl_checker chk (.*);

// ---- dv/testbench.sv ----
// testbench.sv: self-checking bench for spfs_ctrl with OP_CYCLES 8
// assumes inputs change at falling edges; outputs sampled there too
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 0, rst_i = 1, rd_req_i = 0, spm_req_i = 0, concurrent_region_read_reenable_i = 0;
	logic [1:0] boot_size_fuses_i = 0, lock_set0_i = 3, lock_set1_i = 3, spm_op_i = 0;
	logic [11:0] rd_addr_i = 0, pc_i = 12'hc00, spm_ptr_i = 0, arr_addr_o;
	logic [15:0] spm_data_i = 16'h1234, arr_rdata_i, rd_data_o, arr_wdata_o;
	logic rd_valid_o, spm_ack_o, spm_rejected_o, core_stall_o, concurrent_region_busy_flag_o;
	logic spm_busy_o, arr_rd_o, arr_erase_o, arr_write_o, arr_load_o;
	integer fail_count = 0, tests_run = 0, i;
	// lock0, lock1, pc, address, expected read data
	logic [43:0] rows [5] = '{{2'h3, 2'h3, 12'hc00, 12'h010, 16'ha010},
		{2'h3, 2'h3, 12'h000, 12'hc10, 16'hac10}, {2'h1, 2'h3, 12'hc00, 12'h010, 16'hffff},
		{2'h3, 2'h1, 12'h000, 12'hc10, 16'hffff}, {2'h3, 2'h1, 12'hc00, 12'hc10, 16'hac10}};
	spfs_ctrl #(.OP_CYCLES(18'h00008)) dut (.*);
	spfs_arr_model arr (.addr_i(arr_addr_o), .rdata_o(arr_rdata_i));
	always #12.5 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////
	task chk(input [15:0] a, input [15:0] b);
		tests_run++;
		if (a !== b) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, a, b);
		end
	endtask
	// one-cycle pulses, so each request meets exactly one edge
	task store_program_instruction(input [11:0] pc, input [1:0] op, input [11:0] p);
		@(negedge mclk_i) {pc_i, spm_op_i, spm_ptr_i, spm_req_i} = {pc, op, p, 1'b1};
		@(negedge mclk_i) spm_req_i = 0;
	endtask
	task rd(input [11:0] pc, input [11:0] a, input [15:0] e);
		@(negedge mclk_i) {pc_i, rd_addr_i, rd_req_i} = {pc, a, 1'b1};
		@(negedge mclk_i) rd_req_i = 0;
		chk({15'h0, arr_rd_o}, {15'h0, e != 16'hffff});
		// data returns one edge after the address reaches the array
		@(negedge mclk_i);
		chk(rd_data_o, e);
		chk({15'h0, rd_valid_o}, 16'h1);
	endtask
	task idle;
		for (i = 0; i < 40 && spm_busy_o !== 1'b0; i++) @(negedge mclk_i);
		chk({15'h0, spm_busy_o}, 16'h0);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog well past the hundred or so cycles the tests need
	initial begin
		#50000;
		fail_count++;
		test_done;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge mclk_i);
		chk({rd_data_o[7:0], 4'h0, core_stall_o, spm_busy_o, spm_ack_o, rd_valid_o}, 16'hff00);
		rst_i = 0;
		for (int r = 0; r < 5; r++) begin
			{lock_set0_i, lock_set1_i} = rows[r][43:40];
			rd(rows[r][39:28], rows[r][27:16], rows[r][15:0]);
		end
		{lock_set0_i, lock_set1_i} = 4'hf;
		$display("reads done");
		store_program_instruction(12'h000, 2'h1, 12'h010);
		chk({spm_ack_o, spm_rejected_o}, 16'h1);
		boot_size_fuses_i = 3;
		store_program_instruction(12'hf00, 2'h1, 12'h010);
		chk({spm_ack_o, spm_rejected_o}, 16'h1);
		boot_size_fuses_i = 0;
		lock_set0_i = 2;
		store_program_instruction(12'hc00, 2'h1, 12'h010);
		chk({15'h0, spm_ack_o}, 16'h0);
		lock_set0_i = 3;
		lock_set1_i = 2;
		store_program_instruction(12'hc00, 2'h2, 12'hc40);
		chk({spm_ack_o, spm_rejected_o}, 16'h1);
		lock_set1_i = 3;
		$display("refusals done");
		store_program_instruction(12'hc00, 2'h1, 12'h010);
		chk({core_stall_o, concurrent_region_busy_flag_o, spm_ack_o}, 16'h3);
		chk({arr_erase_o, arr_write_o, arr_load_o, 1'b0, arr_addr_o}, 16'h8010);
		rd(12'hc00, 12'h010, 16'hffff);
		rd(12'hc00, 12'hc10, 16'hac10);
		idle;
		chk({15'h0, concurrent_region_busy_flag_o}, 16'h1);
		@(negedge mclk_i) concurrent_region_read_reenable_i = 1;
		@(negedge mclk_i) concurrent_region_read_reenable_i = 0;
		chk({15'h0, concurrent_region_busy_flag_o}, 16'h0);
		rd(12'hc00, 12'h010, 16'ha010);
		$display("concurrent erase done");
		store_program_instruction(12'hc00, 2'h2, 12'hc40);
		chk({core_stall_o, concurrent_region_busy_flag_o}, 16'h2);
		chk({1'b0, arr_write_o, 2'h0, arr_addr_o}, 16'h4c40);
		chk(arr_wdata_o, 16'h1234);
		idle;
		chk({15'h0, core_stall_o}, 16'h0);
		store_program_instruction(12'hc00, 2'h1, 12'h010);
		idle;
		store_program_instruction(12'hc00, 2'h0, 12'h010);
		chk({concurrent_region_busy_flag_o, spm_ack_o}, 16'h1);
		chk({15'h0, arr_load_o}, 16'h1);
		// lock-bit store: ack only, array untouched
		store_program_instruction(12'hc00, 2'h3, 12'h010);
		chk({spm_ack_o, arr_erase_o, arr_write_o, arr_load_o, spm_busy_o}, 16'h10);
		$display("halting write and load done");
		// reset in the middle of a concurrent write
		store_program_instruction(12'hc00, 2'h2, 12'h020);
		@(negedge mclk_i) rst_i = 1;
		@(negedge mclk_i) rst_i = 0;
		chk({core_stall_o, concurrent_region_busy_flag_o, spm_busy_o}, 16'h0);
		rd(12'hc00, 12'h020, 16'ha020);
		$display("mid-run reset done");
		test_done;
	end
endmodule
